/* File: hdl/slcd_map.svh */
// Timing counts and field sizes of the serial segment driver pair
`ifndef SLCD_MAP_SVH
`define SLCD_MAP_SVH

`define SLCD_SEG_COUNT 32
`define SLCD_BP_DIV_BITS 8
`define SLCD_REF_NS 5
`define SLCD_SCLK_HALF_NS 334
`define SLCD_SCLK_HALF_CYC \
	((`SLCD_SCLK_HALF_NS + `SLCD_REF_NS - 1) / `SLCD_REF_NS)
`define SLCD_LOAD_NS 200
`define SLCD_LOAD_CYC ((`SLCD_LOAD_NS + `SLCD_REF_NS - 1) / `SLCD_REF_NS)
`define SLCD_HOST_PH_HALF 200
`define SLCD_IDLE_CYC 1024
`define SLCD_FIFO_WIDTH 32
`define SLCD_FIFO_DEPTH 8

`endif

/* File: hdl/slcd_pkg.sv */
// Frame type shared by both ends of the serial segment driver link, and the host state encoding
package slcd_pkg;
	typedef logic [31:0] slcd_frame_type;
	typedef enum logic [2:0] {
		SLCD_IDLE = 3'b000,
		SLCD_HIGH = 3'b001,
		SLCD_LOW = 3'b010,
		SLCD_LOAD = 3'b011,
		SLCD_TAIL = 3'b100
	} slcd_host_state_type;
endpackage

/* File: hdl/slcd_link_if.sv */
// Three-wire serial link plus shared phase pin between host and driver
`timescale 1ns/1ps
interface slcd_link_if;
	logic shift_clk;
	logic serial_data;
	logic load;
	logic serial_out;
	logic phase_host_o;
	logic phase_host_oe;
	logic phase_dev_o;
	logic phase_dev_oe;
	logic phase_wire;

	// An outside driver overpowers the weak on-chip oscillator
	assign phase_wire = phase_host_oe ? phase_host_o :
		(phase_dev_oe ? phase_dev_o : 1'b0);

	modport dev (
		input shift_clk,
		input serial_data,
		input load,
		output serial_out,
		output phase_dev_o,
		output phase_dev_oe,
		input phase_wire
	);
	modport host (
		output shift_clk,
		output serial_data,
		output load,
		input serial_out,
		output phase_host_o,
		output phase_host_oe,
		input phase_wire
	);
endinterface

/* File: hdl/slcd_driver.sv */
// Serial-input segment driver: shift register, latches and backplane
`timescale 1ns/1ps
`include "slcd_map.svh"
module slcd_driver (
	input wire logic ref_clk,
	input wire logic sys_rst,
	slcd_link_if.dev lk,
	output logic [`SLCD_SEG_COUNT-1:0] segment_output,
	output logic backplane_out,
	output logic phase_driven
);
	import slcd_pkg::*;

	// Link domain: clocked only by the host's shift clock, no reset
	slcd_frame_type sr_q;
	slcd_frame_type sr_d;
	logic dout_q;
	logic dout_d;

	always_comb begin
		// Newest bit enters at index 0, so index N-1 is N pulses old
		sr_d = {sr_q[`SLCD_SEG_COUNT-2:0], lk.serial_data};
		dout_d = sr_q[`SLCD_SEG_COUNT-2];
	end

	always_ff @(negedge lk.shift_clk) begin
		sr_q <= sr_d;
		dout_q <= dout_d;
	end

	// Serial out equals the stage that just became the last one
	assign lk.serial_out = dout_q;

	// Reference domain: load and phase pin are foreign, two flops for load, three for the phase pin
	logic ld_s1_q;
	logic ld_s2_q;
	logic ph_s1_q;
	logic ph_s2_q;
	logic ph_s3_q;
	slcd_frame_type latch_q;
	slcd_frame_type latch_d;
	logic [`SLCD_BP_DIV_BITS:0] div_q;
	logic [`SLCD_BP_DIV_BITS:0] div_d;
	logic own_d1_q;
	logic own_d2_q;
	logic drv_q;
	logic drv_d;
	logic [10:0] idle_q;
	logic [10:0] idle_d;
	logic bp_q;
	logic bp_d;
	logic [`SLCD_SEG_COUNT-1:0] seg_q;
	logic [`SLCD_SEG_COUNT-1:0] seg_d;
	logic oe_q;
	logic oe_d;
	logic oe_p1_q;
	logic oe_p2_q;

	always_comb begin
		latch_d = latch_q;
		// Shift register is still while load is high, so the copy is safe
		if (ld_s2_q) begin
			latch_d = sr_q;
		end
		// Otherwise the latches keep what they had
		div_d = div_q + 1'b1;
		drv_d = drv_q;
		idle_d = idle_q;
		if (ph_s2_q != ph_s3_q) begin
			idle_d = 11'h000;
		end else if (idle_q != 11'h7ff) begin
			idle_d = idle_q + 11'h001;
		end
		// Pin not following our own drive means someone else drives it
		// Pin sample trails our enable by two flops, so wait for it
		if (!drv_q && oe_q && oe_p2_q && (ph_s2_q != own_d2_q)) begin
			drv_d = 1'b1;
			idle_d = 11'h000;
		end else if (drv_q && (idle_q >= 11'(`SLCD_IDLE_CYC))) begin
			// A silent pin means the outside source went away
			drv_d = 1'b0;
		end
		oe_d = !drv_d;
		if (drv_q) begin
			bp_d = ph_s2_q;
		end else begin
			// Pin oscillates at half rate, backplane is that over 2^8
			bp_d = div_q[`SLCD_BP_DIV_BITS];
		end
		// Visible segment is antiphase to backplane, blank is in phase
		seg_d = latch_q ^ {`SLCD_SEG_COUNT{bp_d}};
	end

	always_ff @(posedge ref_clk) begin
		ld_s1_q <= lk.load;
		ld_s2_q <= ld_s1_q;
		ph_s1_q <= lk.phase_wire;
		ph_s2_q <= ph_s1_q;
		ph_s3_q <= ph_s2_q;
		own_d1_q <= div_q[0];
		own_d2_q <= own_d1_q;
		oe_p1_q <= oe_q;
		oe_p2_q <= oe_p1_q;
		if (sys_rst) begin
			latch_q <= '0;
			div_q <= '0;
			drv_q <= 1'b0;
			idle_q <= 11'h000;
			bp_q <= 1'b0;
			seg_q <= '0;
			oe_q <= 1'b1;
		end else begin
			latch_q <= latch_d;
			div_q <= div_d;
			drv_q <= drv_d;
			idle_q <= idle_d;
			bp_q <= bp_d;
			seg_q <= seg_d;
			oe_q <= oe_d;
		end
	end

	assign lk.phase_dev_o = div_q[0];
	assign lk.phase_dev_oe = oe_q;
	assign segment_output = seg_q;
	assign backplane_out = bp_q;
	assign phase_driven = drv_q;
endmodule

/* File: hdl/slcd_host.sv */
// Host end: frame FIFO and three-wire shifter that feeds the driver
`timescale 1ns/1ps
`include "slcd_map.svh"
module slcd_fifo #(
	parameter int WIDTH = `SLCD_FIFO_WIDTH,
	parameter int DEPTH = `SLCD_FIFO_DEPTH
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0] cnt_q;
	logic [AW:0] cnt_d;
	logic rdy_q;
	logic push;
	logic pop;

	always_comb begin
		push = in_valid && rdy_q;
		pop = out_ready && (cnt_q != '0);
		cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem_q[wp_q] <= in_data;
		end
		if (sys_rst) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
			rdy_q <= 1'b0;
		end else begin
			wp_q <= push ? AW'((wp_q + 1'b1) % DEPTH) : wp_q;
			rp_q <= pop ? AW'((rp_q + 1'b1) % DEPTH) : rp_q;
			cnt_q <= cnt_d;
			// Registered ready; full is known from the next count
			rdy_q <= (cnt_d != (AW+1)'(DEPTH));
		end
	end

	assign in_ready = rdy_q;
	assign out_valid = (cnt_q != '0);
	assign out_data = mem_q[rp_q];
endmodule

module slcd_host (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input slcd_pkg::slcd_frame_type frame_data,
	input wire logic frame_valid,
	output logic frame_ready,
	input wire logic phase_drive_en,
	output logic busy,
	slcd_link_if.host lk
);
	import slcd_pkg::*;

	slcd_frame_type f_data;
	logic f_valid;
	logic f_pop;
	slcd_host_state_type st_q;
	slcd_host_state_type st_d;
	slcd_frame_type sh_q;
	slcd_frame_type sh_d;
	logic [5:0] bit_q;
	logic [5:0] bit_d;
	logic [7:0] tm_q;
	logic [7:0] tm_d;
	logic sclk_q;
	logic sclk_d;
	logic dat_q;
	logic dat_d;
	logic ld_q;
	logic ld_d;
	logic [7:0] pc_q;
	logic [7:0] pc_d;
	logic ph_q;
	logic ph_d;
	logic phoe_q;
	logic busy_q;

	slcd_fifo #(.WIDTH(`SLCD_FIFO_WIDTH), .DEPTH(`SLCD_FIFO_DEPTH)) u_fifo (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.in_data(frame_data),
		.in_valid(frame_valid),
		.in_ready(frame_ready),
		.out_data(f_data),
		.out_valid(f_valid),
		.out_ready(f_pop)
	);

	assign f_pop = (st_q == SLCD_IDLE);

	always_comb begin
		st_d = st_q;
		sh_d = sh_q;
		bit_d = bit_q;
		tm_d = (tm_q != 8'h00) ? tm_q - 8'h01 : 8'h00;
		sclk_d = sclk_q;
		dat_d = dat_q;
		ld_d = ld_q;
		case (st_q)
			SLCD_IDLE: begin
				if (f_valid) begin
					// Oldest bit goes first so it ends in segment 32
					sh_d = f_data;
					bit_d = 6'd0;
					st_d = SLCD_HIGH;
					tm_d = 8'(`SLCD_SCLK_HALF_CYC);
					dat_d = f_data[`SLCD_SEG_COUNT-1];
				end
			end
			SLCD_HIGH: begin
				if (tm_q == 8'h00) begin
					// Data changed half a period ago, stable at this fall
					sclk_d = 1'b0;
					st_d = SLCD_LOW;
					tm_d = 8'(`SLCD_SCLK_HALF_CYC);
				end
			end
			SLCD_LOW: begin
				if (tm_q == 8'h00) begin
					if (bit_q == 6'(`SLCD_SEG_COUNT - 1)) begin
						// Load moves only while the clock stands low
						ld_d = 1'b1;
						st_d = SLCD_LOAD;
						tm_d = 8'(`SLCD_LOAD_CYC);
					end else begin
						sclk_d = 1'b1;
						bit_d = bit_q + 6'd1;
						sh_d = {sh_q[`SLCD_SEG_COUNT-2:0], 1'b0};
						dat_d = sh_q[`SLCD_SEG_COUNT-2];
						st_d = SLCD_HIGH;
						tm_d = 8'(`SLCD_SCLK_HALF_CYC);
					end
				end
			end
			SLCD_LOAD: begin
				if (tm_q == 8'h00) begin
					ld_d = 1'b0;
					st_d = SLCD_TAIL;
					tm_d = 8'(`SLCD_SCLK_HALF_CYC);
				end
			end
			SLCD_TAIL: begin
				if (tm_q == 8'h00) begin
					sclk_d = 1'b1;
					st_d = SLCD_IDLE;
				end
			end
			default: begin
				st_d = SLCD_IDLE;
			end
		endcase
		// Host phase toggles every SLCD_HOST_PH_HALF cycles; the driver times the display itself unless the pin is driven
		pc_d = pc_q + 8'h01;
		ph_d = ph_q;
		if (pc_q == 8'(`SLCD_HOST_PH_HALF - 1)) begin
			pc_d = 8'h00;
			ph_d = !ph_q;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			st_q <= SLCD_IDLE;
			sh_q <= '0;
			bit_q <= 6'd0;
			tm_q <= 8'h00;
			sclk_q <= 1'b1;
			dat_q <= 1'b0;
			ld_q <= 1'b0;
			pc_q <= 8'h00;
			ph_q <= 1'b0;
			phoe_q <= 1'b0;
			busy_q <= 1'b0;
		end else begin
			st_q <= st_d;
			sh_q <= sh_d;
			bit_q <= bit_d;
			tm_q <= tm_d;
			sclk_q <= sclk_d;
			dat_q <= dat_d;
			ld_q <= ld_d;
			pc_q <= pc_d;
			ph_q <= ph_d;
			phoe_q <= phase_drive_en;
			busy_q <= (st_d != SLCD_IDLE);
		end
	end

	assign lk.shift_clk = sclk_q;
	assign lk.serial_data = dat_q;
	assign lk.load = ld_q;
	assign lk.phase_host_o = ph_q;
	assign lk.phase_host_oe = phoe_q;
	assign busy = busy_q;
endmodule

/* File: verif/slcd_link_properties.sv */
// Link protocol assertions for the segment driver pair
`timescale 1ns/1ps
module slcd_link_properties (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic shift_clk,
	input wire logic serial_data,
	input wire logic load,
	input wire logic serial_out,
	input wire logic phase_host_o,
	input wire logic phase_host_oe,
	input wire logic phase_dev_o,
	input wire logic phase_dev_oe
);
	logic clk_q, clk_d, fall;
	logic [31:0] hist_q, hist_d;
	logic [6:0] seen_q, seen_d, falls_q, falls_d;
	// Falls show a ref cycle late, far inside the half period
	always_comb begin
		fall = clk_q && !shift_clk;
		clk_d = shift_clk;
		hist_d = fall ? {hist_q[30:0], serial_data} : hist_q;
		seen_d = (fall && seen_q < 7'd32) ? seen_q + 7'd1 : seen_q;
		falls_d = load ? 7'd0 : falls_q + {6'd0, fall};
	end
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			clk_q <= 1'b1;
			hist_q <= '0;
			seen_q <= '0;
			falls_q <= '0;
		end else begin
			clk_q <= clk_d;
			hist_q <= hist_d;
			seen_q <= seen_d;
			falls_q <= falls_d;
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	AST_FRAME_LEN: assert property (
		$rose(load) |-> falls_q == 7'd32)
		else $error("load after wrong bit count");
	AST_LOAD_WIDE: assert property ($rose(load) |-> load[*8])
		else $error("load pulse too short");
	AST_DATA_HOLD: assert property (
		$fell(shift_clk) |-> $stable(serial_data))
		else $error("data moved at clock fall");
	AST_LOAD_HOLD: assert property (
		$fell(shift_clk) |-> $stable(load))
		else $error("load moved at clock fall");
	AST_CLK_RATE: assert property (
		$changed(shift_clk) |=> $stable(shift_clk)[*8])
		else $error("shift clock too fast");
	AST_OUT_ON_FALL: assert property (
		$changed(serial_out) |-> $fell(shift_clk))
		else $error("serial out moved off a fall");
	// Next chip takes the output as it stood before this fall
	AST_CASCADE: assert property (
		$fell(shift_clk) && seen_q == 7'd32 |->
		$past(serial_out) == hist_q[31])
		else $error("serial out not 32 bits late");
	// Divider is held in reset, so the first edge after release is skipped
	AST_OSC: assert property (
		!phase_host_oe && phase_dev_oe && $past(phase_dev_oe) &&
		!$past(sys_rst) |-> $changed(phase_dev_o))
		else $error("oscillator stalled");
	AST_HOST_PHASE: assert property (
		phase_host_oe && $changed(phase_host_o) |=>
		$stable(phase_host_o)[*8])
		else $error("host phase too fast");
	cover property ($rose(load));
	cover property (phase_host_oe && $changed(phase_host_o));
	cover property ($fell(shift_clk) && seen_q == 7'd32);
endmodule

/* File: verif/tb.sv */
// Self-checking bench: host and driver joined over the link
`timescale 1ns/1ps
module tb;
	import slcd_pkg::*;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	slcd_frame_type frame_data = '0;
	logic frame_valid = 1'b0;
	logic phase_drive_en = 1'b0;
	logic frame_ready, busy, backplane_out, phase_driven;
	logic [31:0] segment_output;
	slcd_frame_type fr [9];
	int miscompares = 0;
	int n_checks = 0;
	int t;
	always #2.5 ref_clk = ~ref_clk;
	slcd_link_if lk ();
	slcd_host u_slcd_host (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.frame_data(frame_data), .frame_valid(frame_valid),
		.frame_ready(frame_ready), .phase_drive_en(phase_drive_en),
		.busy(busy), .lk(lk));
	slcd_driver u_slcd_driver (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.lk(lk), .segment_output(segment_output),
		.backplane_out(backplane_out), .phase_driven(phase_driven));
	slcd_link_properties u_slcd_link_properties (.ref_clk(ref_clk),
		.sys_rst(sys_rst), .shift_clk(lk.shift_clk),
		.serial_data(lk.serial_data), .load(lk.load),
		.serial_out(lk.serial_out), .phase_host_o(lk.phase_host_o),
		.phase_host_oe(lk.phase_host_oe), .phase_dev_o(lk.phase_dev_o),
		.phase_dev_oe(lk.phase_dev_oe));
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	// Bounded wait for a change of the backplane or the host phase
	task automatic until_chg(input bit sel, output int n);
		logic b;
		b = sel ? lk.phase_host_o : backplane_out;
		n = 0;
		while ((sel ? lk.phase_host_o : backplane_out) === b &&
			n < 2000) begin
			@(negedge ref_clk);
			n++;
		end
	endtask
	initial begin
		#450us;
		miscompares++;
		complete_run();
	end
	initial begin
		cyc(2);
		sys_rst = 1'b0;
		cyc(2);
		until_chg(0, t);
		until_chg(0, t);
		check(t, 256);
		phase_drive_en = 1'b1;
		cyc(300);
		check(phase_driven, 1'b1);
		until_chg(1, t);
		cyc(20);
		check(backplane_out, lk.phase_wire);
		phase_drive_en = 1'b0;
		cyc(2100);
		check(phase_driven, 1'b0);
		for (int i = 0; i < 9; i++)
			fr[i] = 32'h8000_0001 | (32'h0000_0100 << i);
		fr[0] = 32'h0004_0000;
		fr[1] = 32'hffff_ffff;
		fork
			begin
				// Nine pushes fill the eight-word buffer while the first frame shifts
				for (int i = 0; i < 9; i++) begin
					frame_data = fr[i];
					frame_valid = 1'b1;
					while (frame_ready !== 1'b1) @(negedge ref_clk);
					@(negedge ref_clk);
				end
				frame_valid = 1'b0;
			end
			for (int i = 0; i < 9; i++) begin
				t = 0;
				while (lk.load !== 1'b1 && t < 6000) begin
					@(negedge ref_clk);
					t++;
				end
				check(busy, 1'b1);
				cyc(60);
				check(segment_output ^ {32{backplane_out}}, fr[i]);
				cyc(2000);
				check(segment_output ^ {32{backplane_out}}, fr[i]);
			end
		join
		check(busy, 1'b0);
		check(frame_ready, 1'b1);
		complete_run();
	end
endmodule
